// >>> src/bmd_pkg.sv
package bmd_pkg;
    localparam int BMD_BANK_AW = 7;
    localparam int BMD_FULL_AW = 9;
    localparam int BMD_DW      = 8;
    // In-bank offsets of the core registers, decoded identically in all banks.
    localparam logic [6:0] BMD_OFS_INDIRECT_DATA_PORT = 7'h00;
    localparam logic [6:0] BMD_OFS_PROGRAM_COUNTER_LOW = 7'h02;
    localparam logic [6:0] BMD_OFS_CORE_STATUS_WORD    = 7'h03;
    localparam logic [6:0] BMD_OFS_INDIRECT_POINTER    = 7'h04;
    localparam logic [6:0] BMD_OFS_PROGRAM_COUNTER_LATCH = 7'h0a;
    localparam logic [6:0] BMD_OFS_INTERRUPT_CONTROL   = 7'h0b;
    // Storage windows.
    localparam logic [6:0] BMD_OFS_SPECIAL_TOP     = 7'h1f;
    localparam logic [6:0] BMD_OFS_STORE_BASE      = 7'h20;
    localparam logic [6:0] BMD_OFS_BANK1_STORE_TOP = 7'h3f;
    localparam logic [6:0] BMD_OFS_SHARED_BASE = 7'h70;
    // Status bit positions.
    localparam int BMD_STAT_INDIRECT_BANK_BIT = 7;
    localparam int BMD_STAT_BANK_SELECT_HIGH  = 6;
    localparam int BMD_STAT_BANK_SELECT_LOW   = 5;
    // Reset values.
    localparam logic [7:0] BMD_RST_STATUS  = 8'h18;
    localparam logic [7:0] BMD_RST_POINTER = 8'h00;
    localparam logic [7:0] BMD_RST_PC_LOW    = 8'h00;
    localparam logic [7:0] BMD_RST_PC_LATCH  = 8'h00;
    localparam logic [7:0] BMD_RST_INT_CTRL  = 8'h00;
    localparam logic [4:0] BMD_PC_LATCH_MASK = 5'h1f;
endpackage : bmd_pkg

// >>> src/bmd_gpr_ram.sv
`timescale 1ns/10ps
`default_nettype none
module bmd_store_ram #(
    parameter int DEPTH = 128,
    parameter int AW    = 7,
    parameter int DW    = 8
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    // Plain static storage; contents hold until overwritten.
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule : bmd_store_ram
`default_nettype wire

// >>> src/bmd_decoder.sv
// How it works
// - Each bank is 128 eight-bit locations.
// - Direct access uses seven-bit opcode field.
// - Indirect access uses full pointer byte.
// - Indirect ninth bit comes from status bit 7.
// - Special registers other than status hold value until written.
// - Direct bank from status bits 6:5.
// - Special registers occupy lowest 32 locations.
// - Upper sixteen of banks 1-3 alias bank 0.
// - Unimplemented locations read zero, ignore writes.
`timescale 1ns/10ps
`default_nettype none
module bmd_decoder
    import bmd_pkg::*;
#(
    parameter int STORE_DEPTH = 128
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       acc_en,
    input  wire logic       acc_we,
    input  wire logic [6:0] acc_field,
    input  wire logic [7:0] acc_wdata,
    input  wire logic       status_upd,
    input  wire logic [7:0] status_upd_val,
    output logic      [7:0] acc_rdata_q,
    output logic            acc_valid_q,
    output logic      [8:0] acc_addr_q,
    output logic      [7:0] core_status_word_q,
    output logic      [7:0] indirect_pointer_q,
    output logic      [7:0] program_counter_low_q,
    output logic      [4:0] program_counter_latch_q,
    output logic      [7:0] interrupt_control_q
);
    // ---------------------------------------------------------------
    // Address formation
    // ---------------------------------------------------------------
    wire logic       is_indirect;
    wire logic [8:0] full_addr;
    wire logic [1:0] bank;
    wire logic [6:0] ofs;
    assign is_indirect = (acc_field == BMD_OFS_INDIRECT_DATA_PORT);
    assign full_addr = is_indirect
        ? {core_status_word_q[BMD_STAT_INDIRECT_BANK_BIT], indirect_pointer_q}
        : {core_status_word_q[BMD_STAT_BANK_SELECT_HIGH],
           core_status_word_q[BMD_STAT_BANK_SELECT_LOW], acc_field};
    assign bank = full_addr[8:7];
    assign ofs  = full_addr[6:0];

    // ---------------------------------------------------------------
    // Region decode
    // ---------------------------------------------------------------
    wire logic       in_special;
    wire logic       in_bank0_store;
    wire logic       in_shared;
    wire logic       in_bank1_store;
    wire logic       store_hit;
    wire logic [6:0] ram_addr;
    assign in_special     = (ofs <= BMD_OFS_SPECIAL_TOP);
    assign in_shared      = (ofs >= BMD_OFS_SHARED_BASE);
    assign in_bank0_store = (bank == 2'b00) && !in_special;
    assign in_bank1_store = (bank == 2'b01) && !in_special
                            && (ofs <= BMD_OFS_BANK1_STORE_TOP);
    assign store_hit = in_bank0_store || in_shared || in_bank1_store;
    // Bank 1 storage reuses the unused bank 0 special-space rows of the array.
    assign ram_addr  = in_bank1_store ? (ofs - BMD_OFS_STORE_BASE) : ofs;

    wire logic hit_pc_low;
    wire logic hit_stat;
    wire logic hit_ptr;
    wire logic hit_latch;
    wire logic hit_intc;
    wire logic hit_port;
    wire logic core_hit;
    assign hit_port   = (ofs == BMD_OFS_INDIRECT_DATA_PORT);
    assign hit_pc_low = (ofs == BMD_OFS_PROGRAM_COUNTER_LOW);
    assign hit_stat  = (ofs == BMD_OFS_CORE_STATUS_WORD);
    assign hit_ptr   = (ofs == BMD_OFS_INDIRECT_POINTER);
    assign hit_latch = (ofs == BMD_OFS_PROGRAM_COUNTER_LATCH);
    assign hit_intc  = (ofs == BMD_OFS_INTERRUPT_CONTROL);
    // The indirect port is left out: it is no storage and reads as zero.
    assign core_hit  = hit_pc_low || hit_stat || hit_ptr || hit_latch || hit_intc;

    wire logic wr;
    assign wr = acc_en && acc_we;

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    wire logic [7:0] ram_rdata;
    bmd_store_ram #(.DEPTH(STORE_DEPTH), .AW(BMD_BANK_AW), .DW(BMD_DW)) u_ram (
        .clk   (clk),
        .we    (wr && store_hit),
        .waddr (ram_addr),
        .wdata (acc_wdata),
        .raddr (ram_addr),
        .rdata (ram_rdata)
    );

    // An indirect read through the port at address 0 itself returns zero.
    wire logic [7:0] rd_mux;
    assign rd_mux = store_hit  ? ram_rdata :
                    hit_pc_low ? program_counter_low_q :
                    hit_stat  ? core_status_word_q :
                    hit_ptr   ? indirect_pointer_q :
                    hit_latch ? {3'b000, program_counter_latch_q} :
                    hit_intc  ? interrupt_control_q : 8'h00;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_status_word_q      <= BMD_RST_STATUS;
            indirect_pointer_q      <= BMD_RST_POINTER;
            program_counter_low_q   <= BMD_RST_PC_LOW;
            program_counter_latch_q <= BMD_PC_LATCH_MASK & BMD_RST_PC_LATCH[4:0];
            interrupt_control_q     <= BMD_RST_INT_CTRL;
        end else begin
            // Core flag updates lose to a software write of the same cycle.
            if (wr && hit_stat && !hit_port) begin
                core_status_word_q <= acc_wdata;
            end else if (status_upd) begin
                core_status_word_q <= status_upd_val;
            end
            if (wr && hit_ptr) begin
                indirect_pointer_q <= acc_wdata;
            end
            if (wr && hit_pc_low) begin
                program_counter_low_q <= acc_wdata;
            end
            if (wr && hit_latch) begin
                program_counter_latch_q <= acc_wdata[4:0];
            end
            if (wr && hit_intc) begin
                interrupt_control_q <= acc_wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_rdata_q <= 8'h00;
            acc_valid_q <= 1'b0;
            acc_addr_q  <= 9'h000;
        end else begin
            acc_valid_q <= acc_en;
            if (acc_en) begin
                acc_rdata_q <= rd_mux;
                acc_addr_q  <= full_addr;
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_DIRECT_ADDR: assert property (acc_en && acc_field != 7'h00 |=>
        acc_addr_q == {$past(core_status_word_q[6:5]), $past(acc_field)})
        else $error("Direct address formed wrongly.");
    AST_INDIRECT_ADDR: assert property (acc_en && acc_field == 7'h00 |=>
        acc_addr_q == {$past(core_status_word_q[7]), $past(indirect_pointer_q)})
        else $error("Indirect address formed wrongly.");
    AST_PTR_BYTE: assert property (acc_en && is_indirect |=>
        acc_addr_q[7:0] == $past(indirect_pointer_q))
        else $error("Pointer byte not used in full.");
    AST_UNIMPL_ZERO: assert property (acc_en && full_addr[8] && !in_shared
        && !in_special |=> acc_rdata_q == 8'h00)
        else $error("Unimplemented location read nonzero.");
    AST_SPECIAL_ZERO: assert property (acc_en && in_special && !core_hit
        |=> acc_rdata_q == 8'h00)
        else $error("Unused special location read nonzero.");
    AST_PTR_HOLDS: assert property (!(wr && hit_ptr) |=>
        $stable(indirect_pointer_q))
        else $error("Pointer changed without write.");
    AST_PTR_WRITE: assert property (wr && hit_ptr |=>
        indirect_pointer_q == $past(acc_wdata))
        else $error("Pointer write lost.");
    // A write into the shared window followed at once by a read of the same row.
    sequence seq_shared_write;
        wr && in_shared;
    endsequence
    sequence seq_shared_read;
        acc_en && !acc_we && in_shared && ofs == $past(ofs);
    endsequence
    AST_SHARED_ALIAS: assert property (seq_shared_write ##1 seq_shared_read
        |=> acc_rdata_q == $past(acc_wdata, 2))
        else $error("Shared window not aliased.");
    AST_SPECIAL_NO_STORE: assert property (acc_en && in_special |-> !store_hit)
        else $error("Special space hit storage.");
    AST_BANK_SIZE: assert property (acc_en |=> acc_addr_q[6:0] ==
        (($past(acc_field) == 7'h00) ? $past(indirect_pointer_q[6:0]) : $past(acc_field)))
        else $error("Bank offset wrong.");
    AST_STATUS_WRITE: assert property (wr && hit_stat |=>
        core_status_word_q == $past(acc_wdata))
        else $error("Status write lost.");
    AST_STATUS_UPD: assert property (status_upd && !(wr && hit_stat) |=>
        core_status_word_q == $past(status_upd_val))
        else $error("Status flag update lost.");
    AST_LATCH_WRITE: assert property (wr && hit_latch |=>
        program_counter_latch_q == $past(acc_wdata[4:0]))
        else $error("Latch write lost.");
    AST_PC_LOW_WRITE: assert property (wr && hit_pc_low |=>
        program_counter_low_q == $past(acc_wdata))
        else $error("Counter low byte write lost.");
    AST_INTC_HOLDS: assert property (!(wr && hit_intc) |=>
        $stable(interrupt_control_q))
        else $error("Interrupt control changed without write.");
    AST_VALID_HIGH: assert property (acc_en |=> acc_valid_q)
        else $error("Access not answered.");
    AST_VALID_LOW: assert property (!acc_en |=> !acc_valid_q)
        else $error("Answer without access.");
    AST_BANK_SEL: assert property (acc_en && !is_indirect |=>
        acc_addr_q[8:7] == $past(core_status_word_q[6:5]))
        else $error("Bank select wrong.");
endmodule : bmd_decoder
`default_nettype wire

// >>> test/bmd_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module bmd_core_model (
    input  wire logic       clk,
    input  wire logic       req,
    input  wire logic       req_we,
    input  wire logic [6:0] req_field,
    input  wire logic [7:0] req_wdata,
    output logic            acc_en,
    output logic            acc_we,
    output logic      [6:0] acc_field,
    output logic      [7:0] acc_wdata
);
    // Registered issue drives every request cleanly off the edge, one cycle after req.
    always_ff @(posedge clk) begin
        acc_en    <= req;
        acc_we    <= req_we;
        acc_field <= req_field;
        acc_wdata <= req_wdata;
    end
endmodule : bmd_core_model
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic       clk, rst, req, req_we, acc_en, acc_we, status_upd, valid;
    logic [6:0] req_field, acc_field;
    logic [7:0] req_wdata, acc_wdata, status_upd_val, rdata, stat, ptr, int_ctrl, pc_low;
    logic [8:0] addr;
    logic [4:0] pc_latch;
    int         failures, n_tests;
    bmd_core_model core (.clk(clk), .req(req), .req_we(req_we), .req_field(req_field),
        .req_wdata(req_wdata), .acc_en(acc_en), .acc_we(acc_we), .acc_field(acc_field),
        .acc_wdata(acc_wdata));
    bmd_decoder dut (.clk(clk), .rst(rst), .acc_en(acc_en), .acc_we(acc_we),
        .acc_field(acc_field), .acc_wdata(acc_wdata), .status_upd(status_upd),
        .status_upd_val(status_upd_val), .acc_rdata_q(rdata), .acc_valid_q(valid),
        .acc_addr_q(addr), .core_status_word_q(stat), .indirect_pointer_q(ptr),
        .program_counter_low_q(pc_low), .program_counter_latch_q(pc_latch),
        .interrupt_control_q(int_ctrl));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ----------------
    // Shared tasks
    // ----------------
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic acc(input logic we, input logic [6:0] f, input logic [7:0] d);
        @(posedge clk);
        req <= 1'b1;
        req_we <= we;
        req_field <= f;
        req_wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        #1 check("valid", {8'h00, valid}, 9'h001);
    endtask : acc
    task automatic rd(input logic [6:0] f, input logic [7:0] exp);
        acc(1'b0, f, 8'h00);
        check("rdata", {1'b0, rdata}, {1'b0, exp});
    endtask : rd
    task automatic wrap_up;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_reset;
        check("status", {1'b0, stat}, 9'h018);
        check("pointer", {1'b0, ptr}, 9'h000);
        check("latch", {4'h0, pc_latch}, 9'h000);
        check("int_ctrl", {1'b0, int_ctrl}, 9'h000);
        check("pc_low", {1'b0, pc_low}, 9'h000);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_bank;
        acc(1'b1, 7'h03, 8'h00);
        acc(1'b1, 7'h75, 8'h5a);
        for (int b = 0; b < 4; b++) begin
            acc(1'b1, 7'h03, {1'b0, b[1:0], 5'h00});
            rd(7'h75, 8'h5a);
            check("addr", addr, {b[1:0], 7'h75});
        end
        $display("t_bank done");
    endtask : t_bank
    task automatic t_unimpl;
        acc(1'b1, 7'h03, 8'h00);
        acc(1'b1, 7'h20, 8'h11);
        acc(1'b1, 7'h03, 8'h60);
        acc(1'b1, 7'h20, 8'ha5);
        rd(7'h20, 8'h00);
        acc(1'b1, 7'h03, 8'h20);
        acc(1'b1, 7'h21, 8'h22);
        rd(7'h40, 8'h00);
        rd(7'h1f, 8'h00);
        rd(7'h21, 8'h22);
        acc(1'b1, 7'h03, 8'h00);
        rd(7'h20, 8'h11);
        $display("t_unimpl done");
    endtask : t_unimpl
    task automatic t_ind;
        acc(1'b1, 7'h04, 8'ha5);
        check("pointer", {1'b0, ptr}, 9'h0a5);
        acc(1'b1, 7'h03, 8'h00);
        acc(1'b1, 7'h00, 8'h3c);
        check("addr", addr, 9'h0a5);
        acc(1'b1, 7'h03, 8'h20);
        rd(7'h25, 8'h3c);
        acc(1'b1, 7'h03, 8'h80);
        acc(1'b1, 7'h72, 8'hc3);
        acc(1'b1, 7'h04, 8'hf2);
        rd(7'h00, 8'hc3);
        check("addr", addr, 9'h1f2);
        $display("t_ind done");
    endtask : t_ind
    task automatic t_core;
        acc(1'b1, 7'h03, 8'h60);
        acc(1'b1, 7'h0a, 8'hff);
        acc(1'b1, 7'h0b, 8'h81);
        acc(1'b1, 7'h02, 8'h34);
        acc(1'b1, 7'h03, 8'h00);
        check("latch", {4'h0, pc_latch}, 9'h01f);
        rd(7'h0b, 8'h81);
        rd(7'h02, 8'h34);
        check("pc_low", {1'b0, pc_low}, 9'h034);
        @(posedge clk);
        status_upd <= 1'b1;
        status_upd_val <= 8'h60;
        @(posedge clk);
        status_upd <= 1'b0;
        repeat (10) @(posedge clk);
        #1 check("bank", {7'h00, stat[6:5]}, 9'h003);
        check("int_ctrl", {1'b0, int_ctrl}, 9'h081);
        // A flag update landing with a status write must lose to the write.
        @(posedge clk);
        req <= 1'b1;
        req_we <= 1'b1;
        req_field <= 7'h03;
        req_wdata <= 8'h00;
        @(posedge clk);
        req <= 1'b0;
        status_upd <= 1'b1;
        status_upd_val <= 8'h60;
        @(posedge clk);
        status_upd <= 1'b0;
        #1 check("race", {1'b0, stat}, 9'h000);
        $display("t_core done");
    endtask : t_core
    task automatic t_b2b;
        acc(1'b1, 7'h03, 8'h80);
        acc(1'b1, 7'h04, 8'h7e);
        @(posedge clk);
        req <= 1'b1;
        req_we <= 1'b1;
        req_field <= 7'h7e;
        req_wdata <= 8'h99;
        @(posedge clk);
        req_we <= 1'b0;
        req_field <= 7'h00;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        #1 check("alias", {1'b0, rdata}, 9'h099);
        check("addr", addr, 9'h17e);
        @(posedge clk);
        #1 check("valid", {8'h00, valid}, 9'h000);
        $display("t_b2b done");
    endtask : t_b2b
    initial begin
        {rst, req, req_we, status_upd} = 4'h8;
        {req_field, req_wdata, status_upd_val} = '0;
        failures = 0;
        n_tests = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_bank;
        t_unimpl;
        t_ind;
        t_core;
        t_b2b;
        wrap_up;
    end
    initial begin
        #100000;
        failures++;
        wrap_up;
    end
endmodule : tb
`default_nettype wire
